// ### logic/lqts_pkg.sv
// Constants shared by the link-quality threshold select block
`default_nettype none
package lqts_pkg;
  // Control word layout
  localparam int unsigned CTRL_W = 16;
  localparam int unsigned READ_PARAM_BIT = 13;
  localparam int unsigned STORE_TRIG_BIT = 12;
  localparam int unsigned SEL_HI_BIT = 11;
  localparam int unsigned SEL_LO_BIT = 9;
  localparam int unsigned LOW_HIGH_BIT = 8;
  localparam int unsigned DATA_HI_BIT = 7;
  localparam int unsigned DATA_LO_BIT = 0;
  localparam int unsigned SEL_W = 3;
  localparam int unsigned BOUND_W = 8;
  localparam int unsigned PARAM_W = 8;
  localparam int unsigned BOUND_COUNT = 8;
  // Parameter selector codes
  localparam logic [2:0] SEL_EQUALIZER = 3'h0;
  localparam logic [2:0] SEL_GAIN = 3'h1;
  localparam logic [2:0] SEL_WANDER = 3'h2;
  localparam logic [2:0] SEL_FREQ_OFFSET = 3'h3;
  localparam logic [2:0] SEL_FREQ_CONTROL = 3'h4;
  // Reset values
  localparam logic [2:0] SEL_RESET = 3'h0;
  localparam logic LOW_HIGH_RESET = 1'b0;
  localparam logic [7:0] BOUND_RESET = 8'h00;
endpackage : lqts_pkg
`default_nettype wire

// ### logic/lqts_bound_store.sv
// Storage for the eight low/high bound values, indexed by {selector, low/high}
`default_nettype none
module lqts_bound_store #(
  parameter int unsigned W = lqts_pkg::BOUND_W,
  parameter int unsigned N = lqts_pkg::BOUND_COUNT
) (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic store_en_in,
  input wire logic [$clog2(N)-1:0] store_idx_in,
  input wire logic [W-1:0] store_data_in,
  input wire logic [$clog2(N)-1:0] read_idx_in,
  output logic [W-1:0] read_data_out,
  output logic [N*W-1:0] all_bounds_out
);
  localparam int unsigned IW = $clog2(N);

  typedef struct packed {
    logic [N-1:0][W-1:0] mem;
  } lqts_store_state_t;

  lqts_store_state_t state_reg;
  lqts_store_state_t state_next;
  logic [N-1:0][W-1:0] entry_next;

  ////////////////////////////////////////////////////////////////////////////
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_entry
      assign entry_next[gi] = (store_en_in && store_idx_in == IW'(gi)) ?
                              store_data_in : state_reg.mem[gi];
    end
  endgenerate

  always_comb begin
    state_next = state_reg;
    state_next.mem = entry_next;
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign read_data_out = state_reg.mem[read_idx_in];
  assign all_bounds_out = state_reg.mem;
endmodule : lqts_bound_store
`default_nettype wire

// ### logic/lqts_select.sv
// Link-quality parameter and threshold selection control
`default_nettype none
module lqts_select #(
  parameter int unsigned PW = lqts_pkg::PARAM_W,
  parameter int unsigned BW = lqts_pkg::BOUND_W
) (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic ctrl_wr_in,
  input wire logic [lqts_pkg::CTRL_W-1:0] ctrl_data_in,
  input wire logic [PW-1:0] equalizer_coefficient_in,
  input wire logic [PW-1:0] gain_control_level_in,
  input wire logic [PW-1:0] baseline_wander_level_in,
  input wire logic [PW-1:0] freq_offset_in,
  input wire logic [PW-1:0] freq_control_in,
  output logic [lqts_pkg::CTRL_W-1:0] ctrl_word_out,
  output logic [2:0] quality_param_selector_out,
  output logic bound_low_high_select_out,
  output logic sampling_active_out,
  output logic [PW-1:0] param_value_out,
  output logic [BW-1:0] bound_value_out
);
  typedef struct packed {
    logic [2:0] sel;
    logic hi;
    logic sampling;
    logic [PW-1:0] sample;
    logic [BW-1:0] bound;
  } lqts_state_t;

  lqts_state_t state_reg;
  lqts_state_t state_next;
  logic [2:0] wr_sel;
  logic wr_trig;
  logic store_en;
  logic [BW-1:0] store_rd;
  logic [lqts_pkg::BOUND_COUNT*BW-1:0] all_bounds;
  logic [PW-1:0] live_value;

  assign wr_sel = ctrl_data_in[lqts_pkg::SEL_HI_BIT:lqts_pkg::SEL_LO_BIT];
  assign wr_trig = ctrl_wr_in && ctrl_data_in[lqts_pkg::STORE_TRIG_BIT];
  // Only codes with bound storage may write; others are dropped silently
  assign store_en = wr_trig && (wr_sel < lqts_pkg::SEL_FREQ_CONTROL);

  ////////////////////////////////////////////////////////////////////////////
  // Store address comes from the written word, so a write lands on the same edge that the selection moves
  lqts_bound_store #(
    .W(BW),
    .N(lqts_pkg::BOUND_COUNT)
  ) u_store (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .store_en_in(store_en),
    .store_idx_in({wr_sel[1:0], ctrl_data_in[lqts_pkg::LOW_HIGH_BIT]}),
    .store_data_in(ctrl_data_in[lqts_pkg::DATA_HI_BIT:lqts_pkg::DATA_LO_BIT]),
    .read_idx_in({state_reg.sel[1:0], state_reg.hi}),
    .read_data_out(store_rd),
    .all_bounds_out(all_bounds)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    case (state_reg.sel)
      lqts_pkg::SEL_EQUALIZER: live_value = equalizer_coefficient_in;
      lqts_pkg::SEL_GAIN: live_value = gain_control_level_in;
      lqts_pkg::SEL_WANDER: live_value = baseline_wander_level_in;
      lqts_pkg::SEL_FREQ_OFFSET: live_value = freq_offset_in;
      lqts_pkg::SEL_FREQ_CONTROL: live_value = freq_control_in;
      default: live_value = '0;
    endcase
  end

  always_comb begin
    state_next = state_reg;
    if (ctrl_wr_in) begin
      state_next.sel = wr_sel;
      state_next.hi = ctrl_data_in[lqts_pkg::LOW_HIGH_BIT];
      state_next.sampling = ctrl_data_in[lqts_pkg::READ_PARAM_BIT];
    end
    // Sample follows the live selection while sampling is enabled
    if (state_reg.sampling) begin
      state_next.sample = live_value;
    end
    // No storage behind code 100 and up: read back zero
    if (state_reg.sel < lqts_pkg::SEL_FREQ_CONTROL) begin
      state_next.bound = store_rd;
    end else begin
      state_next.bound = lqts_pkg::BOUND_RESET;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg.sel <= lqts_pkg::SEL_RESET;
      state_reg.hi <= lqts_pkg::LOW_HIGH_RESET;
      state_reg.sampling <= 1'b0;
      state_reg.sample <= '0;
      state_reg.bound <= lqts_pkg::BOUND_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Store trigger is self-clearing, so it always reads back as zero
  assign ctrl_word_out = {2'b00, state_reg.sampling, 1'b0, state_reg.sel, state_reg.hi,
                          8'h00};
  assign quality_param_selector_out = state_reg.sel;
  assign bound_low_high_select_out = state_reg.hi;
  assign sampling_active_out = state_reg.sampling;
  assign param_value_out = state_reg.sample;
  assign bound_value_out = state_reg.bound;

  ////////////////////////////////////////////////////////////////////////////
  // Checks watch registered outputs and store contents, in the same cycle or one or two cycles after the cause
  AST_SEL_LOAD: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    ctrl_wr_in |=> quality_param_selector_out == $past(wr_sel))
    else $error("selector not loaded from control write");

  AST_SEL_HOLD: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    !ctrl_wr_in |=> $stable(quality_param_selector_out))
    else $error("selector changed without a write");

  AST_LOW_HIGH_LOAD: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    ctrl_wr_in |=> bound_low_high_select_out == $past(ctrl_data_in[lqts_pkg::LOW_HIGH_BIT]))
    else $error("low/high select not loaded");

  AST_LOW_HIGH_HOLD: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    !ctrl_wr_in |=> $stable(bound_low_high_select_out) &&
      ctrl_word_out[lqts_pkg::LOW_HIGH_BIT] == bound_low_high_select_out)
    else $error("low/high select changed without a write");

  AST_WORD_FIELDS: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    ctrl_word_out[lqts_pkg::SEL_HI_BIT:lqts_pkg::SEL_LO_BIT] ==
      quality_param_selector_out &&
      ctrl_word_out[lqts_pkg::READ_PARAM_BIT] == sampling_active_out)
    else $error("control word readback does not match the held fields");

  AST_TRIG_READS_ZERO: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    ctrl_word_out[lqts_pkg::STORE_TRIG_BIT] == 1'b0)
    else $error("store trigger read back as one");

  AST_SAMPLING_LOAD: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    ctrl_wr_in |=> sampling_active_out == $past(ctrl_data_in[lqts_pkg::READ_PARAM_BIT]))
    else $error("sampling enable not loaded from control write");

  AST_SAMPLE_START: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    ctrl_wr_in && ctrl_data_in[lqts_pkg::READ_PARAM_BIT] |=> sampling_active_out ##1
      param_value_out == $past(live_value))
    else $error("sampling did not start or track the selected parameter");

  AST_SAMPLE_HOLD: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    !sampling_active_out |=> $stable(param_value_out))
    else $error("sample moved while sampling was off");

  AST_LIVE_EQUALIZER: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    sampling_active_out && quality_param_selector_out == lqts_pkg::SEL_EQUALIZER |=>
      param_value_out == $past(equalizer_coefficient_in))
    else $error("equalizer code did not sample the equalizer input");

  AST_LIVE_GAIN: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    sampling_active_out && quality_param_selector_out == lqts_pkg::SEL_GAIN |=>
      param_value_out == $past(gain_control_level_in))
    else $error("gain code did not sample the gain input");

  AST_LIVE_WANDER: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    sampling_active_out && quality_param_selector_out == lqts_pkg::SEL_WANDER |=>
      param_value_out == $past(baseline_wander_level_in))
    else $error("wander code did not sample the wander input");

  AST_LIVE_OFFSET: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    sampling_active_out && quality_param_selector_out == lqts_pkg::SEL_FREQ_OFFSET |=>
      param_value_out == $past(freq_offset_in))
    else $error("offset code did not sample the offset input");

  AST_STORE_READBACK: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    wr_trig && wr_sel < lqts_pkg::SEL_FREQ_CONTROL ##1 !ctrl_wr_in |=>
      bound_value_out == $past(ctrl_data_in[lqts_pkg::DATA_HI_BIT:lqts_pkg::DATA_LO_BIT], 2))
    else $error("stored bound not read back at its address");

  AST_STORE_LANDS: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    wr_trig && wr_sel < lqts_pkg::SEL_FREQ_CONTROL |=>
      all_bounds[$past({wr_sel[1:0], ctrl_data_in[lqts_pkg::LOW_HIGH_BIT]}) * BW +: BW] ==
      $past(ctrl_data_in[lqts_pkg::DATA_HI_BIT:lqts_pkg::DATA_LO_BIT]))
    else $error("store trigger did not write the addressed bound");

  AST_STORE_NEEDS_TRIG: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    !wr_trig |=> $stable(all_bounds))
    else $error("bound changed without a store trigger");

  AST_NO_STORE_HIGH: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    ctrl_wr_in && wr_sel >= lqts_pkg::SEL_FREQ_CONTROL |=> $stable(all_bounds))
    else $error("bound changed on write with code 100 or above");

  AST_HIGH_READ_ZERO: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    quality_param_selector_out >= lqts_pkg::SEL_FREQ_CONTROL |=>
      bound_value_out == lqts_pkg::BOUND_RESET)
    else $error("code without storage returned a bound");

  AST_SHARED_SEL: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    sampling_active_out && !ctrl_wr_in &&
      quality_param_selector_out == lqts_pkg::SEL_FREQ_CONTROL |=>
      param_value_out == $past(freq_control_in))
    else $error("live sample not steered by selector");
endmodule : lqts_select
`default_nettype wire

// ### verification/lqts_live_src.sv
// Live receiver parameter source standing in for the sampling datapath
`default_nettype none
module lqts_live_src (
  input wire logic mclk_in,
  output logic [4:0][7:0] live_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_reg = 8'h00;
  // Values move every cycle so a stale or wrong-source sample shows
  always_ff @(posedge mclk_in) begin
    cnt_reg <= cnt_reg + 8'h01;
  end
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      live_out[i] = cnt_reg + 8'(8'h37 * i);
    end
  end
endmodule : lqts_live_src
`default_nettype wire

// ### verification/link_quality_threshold_select_tb.sv
// Self-checking bench for the link-quality threshold select block
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module link_quality_threshold_select_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic wr = 1'b0;
  logic [15:0] data = 16'h0000;
  logic [4:0][7:0] live;
  logic [15:0] word;
  logic [2:0] sel;
  logic hi;
  logic samp;
  logic [7:0] pv;
  logic [7:0] bv;
  logic [7:0] v;
  int err_count = 0;
  int checked = 0;
  always #5 mclk = ~mclk;
  lqts_live_src lqts_live_src_inst (.mclk_in(mclk), .live_out(live));
  lqts_select lqts_select_inst (.mclk_in(mclk), .rst_b_in(rst_b), .ctrl_wr_in(wr),
    .ctrl_data_in(data), .equalizer_coefficient_in(live[0]), .gain_control_level_in(live[1]),
    .baseline_wander_level_in(live[2]), .freq_offset_in(live[3]), .freq_control_in(live[4]),
    .ctrl_word_out(word), .quality_param_selector_out(sel), .bound_low_high_select_out(hi),
    .sampling_active_out(samp), .param_value_out(pv), .bound_value_out(bv));
  function automatic logic [15:0] cw(logic r, logic t, logic [2:0] s, logic h, logic [7:0] d);
    return {2'b00, r, t, s, h, d};
  endfunction : cw
  // Leaves the strobe high; back-to-back calls give one write per cycle
  task automatic wr_word(input logic [15:0] w);
    wr = 1'b1;
    data = w;
    @(posedge mclk);
    #1;
  endtask : wr_word
  task automatic idle(input int n);
    wr = 1'b0;
    repeat (n) begin
      @(posedge mclk);
      #1;
    end
  endtask : idle
  task automatic t_bounds();
    for (int i = 0; i < 8; i++) wr_word(cw(1'b0, 1'b1, 3'(i / 2), i[0], 8'(8'hA0 + i)));
    for (int s = 4; s < 8; s++) wr_word(cw(1'b0, 1'b1, 3'(s), 1'b0, 8'hFF));
    idle(1);
    for (int i = 0; i < 8; i++) begin
      wr_word(cw(1'b0, 1'b0, 3'(i / 2), i[0], 8'h55));
      `CHK("ctrl_word", cw(1'b0, 1'b0, 3'(i / 2), i[0], 8'h00), word)
      `CHK("low_high", i[0], hi)
      idle(1);
      `CHK("bound", 8'(8'hA0 + i), bv)
    end
    for (int s = 4; s < 8; s++) begin
      wr_word(cw(1'b0, 1'b0, 3'(s), 1'b1, 8'h00));
      idle(1);
      `CHK("bound_none", 8'h00, bv)
    end
  endtask : t_bounds
  task automatic t_sample();
    for (int s = 0; s < 5; s++) begin
      wr_word(cw(1'b1, 1'b0, 3'(s), 1'b0, 8'h00));
      `CHK("ctrl_word", cw(1'b1, 1'b0, 3'(s), 1'b0, 8'h00), word)
      `CHK("selector", 3'(s), sel)
      repeat (2) begin
        v = live[s];
        idle(1);
        `CHK("sample", v, pv)
      end
    end
    // Last live value taken at the stopping write's edge must then hold
    v = live[4];
    wr_word(cw(1'b0, 1'b0, 3'h0, 1'b0, 8'h00));
    idle(3);
    `CHK("sample_hold", v, pv)
    `CHK("sampling", 1'b0, samp)
  endtask : t_sample
  // Mid-run reset must clear the stored bounds as well as the controls
  task automatic t_reset();
    idle(1);
    rst_b = 1'b0;
    idle(2);
    `CHK("rerun_word", 16'h0000, word)
    `CHK("rerun_low_high", 1'b0, hi)
    `CHK("rerun_sample", 8'h00, pv)
    rst_b = 1'b1;
    wr_word(cw(1'b0, 1'b0, 3'h0, 1'b1, 8'h00));
    idle(1);
    `CHK("bound_cleared", 8'h00, bv)
  endtask : t_reset
  task automatic complete_run();
    if (err_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run
  initial begin
    #100000;
    err_count++;
    complete_run();
  end
  initial begin
    repeat (6) @(posedge mclk);
    #1;
    `CHK("reset_word", 16'h0000, word)
    `CHK("reset_low_high", 1'b0, hi)
    rst_b = 1'b1;
    t_bounds();
    t_sample();
    t_reset();
    complete_run();
  end
endmodule : link_quality_threshold_select_tb
`default_nettype wire
